// ==== src/ilmp_pkg.sv ====
// Contract
// - Debounced port 2, 3 and 4 interrupts appear on lines 12, 13 and 14.
// - Timer0/2 to line 15, timer1 to 17, calendar clock to 18, DMA to 19.
// - Wake-up capture, port wake and quadrature requests merge onto line 16.
// - Line 20 signals that the 32 MHz crystal has settled.
// - A smaller programmed priority value is more urgent.
// - Each line has an eight-bit programmable priority, zero after reset.
// - Equal priorities are served lowest line number first.
// - The watchdog timeout drives the non-maskable input, never a line.
package ilmp_pkg;

  // ----------------------------------------
  // Line numbering
  // ----------------------------------------
  localparam int unsigned FIRST_LINE = 12;
  localparam int unsigned NUM_LINES  = 9;
  localparam int unsigned IDX_W      = 4;
  localparam int unsigned LINE_W     = 5;
  localparam int unsigned PRIO_W     = 8;

  localparam logic [IDX_W-1:0] IDX_PORT2  = 4'h0;
  localparam logic [IDX_W-1:0] IDX_PORT3  = 4'h1;
  localparam logic [IDX_W-1:0] IDX_PORT4  = 4'h2;
  localparam logic [IDX_W-1:0] IDX_TIM02  = 4'h3;
  localparam logic [IDX_W-1:0] IDX_WAKEQ  = 4'h4;
  localparam logic [IDX_W-1:0] IDX_TIM1   = 4'h5;
  localparam logic [IDX_W-1:0] IDX_CAL    = 4'h6;
  localparam logic [IDX_W-1:0] IDX_DMA    = 4'h7;
  localparam logic [IDX_W-1:0] IDX_XTAL   = 4'h8;

  localparam logic [PRIO_W-1:0] PRIO_RESET = 8'h00;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic port2_debounced_irq;
    logic port3_debounced_irq;
    logic port4_debounced_irq;
    logic timer0_timer2_irq;
    logic wakeup_capture_irq;
    logic port_wake_irq;
    logic quadrature_irq;
    logic timer_one_irq;
    logic calendar_clock_irq;
    logic memory_transfer_irq;
    logic crystal_settled_irq;
  } ilmp_src_t;

  typedef struct packed {
    logic              we;
    logic [IDX_W-1:0]  idx;
    logic [PRIO_W-1:0] prio;
  } ilmp_prio_wr_t;

  typedef struct packed {
    logic              valid;
    logic [LINE_W-1:0] line;
  } ilmp_req_t;

endpackage

// ==== src/ilmp_irq_arbiter.sv ====
`timescale 1ns/100ps
module ilmp_irq_arbiter
  import ilmp_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              reset_in,
  // Peripheral sources
  input  wire ilmp_src_t         src_in,
  input  wire logic              watchdog_irq_in,
  // Software configuration
  input  wire ilmp_prio_wr_t     prio_wr_in,
  input  wire logic [NUM_LINES-1:0] enable_in,
  // Processor side
  input  wire logic              ack_in,
  input  wire logic [LINE_W-1:0] ack_line_in,
  output logic                   nmi_out,
  output ilmp_req_t              req_out,
  output logic [NUM_LINES-1:0]   pending_out
);

  // ----------------------------------------
  // Source mapping
  // ----------------------------------------
  wire logic [NUM_LINES-1:0] raw_w;
  assign raw_w[IDX_PORT2] = src_in.port2_debounced_irq;
  assign raw_w[IDX_PORT3] = src_in.port3_debounced_irq;
  assign raw_w[IDX_PORT4] = src_in.port4_debounced_irq;
  assign raw_w[IDX_TIM02] = src_in.timer0_timer2_irq;
  assign raw_w[IDX_WAKEQ] = src_in.wakeup_capture_irq
                          | src_in.port_wake_irq
                          | src_in.quadrature_irq;
  assign raw_w[IDX_TIM1]  = src_in.timer_one_irq;
  assign raw_w[IDX_CAL]   = src_in.calendar_clock_irq;
  assign raw_w[IDX_DMA]   = src_in.memory_transfer_irq;
  assign raw_w[IDX_XTAL]  = src_in.crystal_settled_irq;

  // ----------------------------------------
  // Priority storage
  // ----------------------------------------
  logic [PRIO_W-1:0] prio_q [NUM_LINES];

  always_ff @(posedge clk_in)
  begin
    for (int i = 0; i < NUM_LINES; i++)
    begin
      if (reset_in)
        prio_q[i] <= PRIO_RESET;
      else if (prio_wr_in.we && prio_wr_in.idx == IDX_W'(i))
        prio_q[i] <= prio_wr_in.prio;
    end
  end

  // ----------------------------------------
  // Pending latch
  // ----------------------------------------
  logic [NUM_LINES-1:0] pending_q;
  logic [NUM_LINES-1:0] pending_d;
  wire  logic [NUM_LINES-1:0] ack_w;

  function automatic logic [IDX_W-1:0] line_to_idx(logic [LINE_W-1:0] l);
    return IDX_W'(l - LINE_W'(FIRST_LINE));
  endfunction

  // Range checked at full width; a narrowed index would alias 28..31 and 0..4
  assign ack_w = (ack_in && ack_line_in >= LINE_W'(FIRST_LINE)
                  && ack_line_in < LINE_W'(FIRST_LINE + NUM_LINES))
               ? (NUM_LINES'(1) << line_to_idx(ack_line_in))
               : '0;
  // New event wins over an acknowledge in the same cycle
  assign pending_d = (pending_q & ~ack_w) | raw_w;

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      pending_q <= '0;
    else
      pending_q <= pending_d;
  end

  // ----------------------------------------
  // Arbitration
  // ----------------------------------------
  logic              win_v;
  logic [IDX_W-1:0]  win_i;
  logic [PRIO_W-1:0] win_p;
  wire  logic [NUM_LINES-1:0] cand_w;
  assign cand_w = pending_q & enable_in;

  // Strict less-than keeps the lowest index on ties
  always_comb
  begin
    win_v = 1'b0;
    win_i = '0;
    win_p = '1;
    for (int i = 0; i < NUM_LINES; i++)
    begin
      if (cand_w[i] && (!win_v || prio_q[i] < win_p))
      begin
        win_v = 1'b1;
        win_i = IDX_W'(i);
        win_p = prio_q[i];
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  ilmp_req_t req_q;
  logic      nmi_q;

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      req_q <= '0;
      nmi_q <= 1'b0;
    end
    else
    begin
      req_q.valid <= win_v;
      req_q.line  <= win_v ? LINE_W'(win_i) + LINE_W'(FIRST_LINE) : '0;
      nmi_q       <= watchdog_irq_in;
    end
  end

  assign req_out     = req_q;
  assign nmi_out     = nmi_q;
  assign pending_out = pending_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_latch;
    @(posedge clk_in) disable iff (reset_in)
    raw_w[IDX_XTAL] |=> pending_q[IDX_XTAL];
  endproperty
  a_latch: assert property (p_latch)
    else $error("settled event not latched");

  property p_merge;
    @(posedge clk_in) disable iff (reset_in)
    src_in.quadrature_irq |=> pending_q[IDX_WAKEQ];
  endproperty
  a_merge: assert property (p_merge)
    else $error("quadrature not on line 16");

  property p_hold;
    @(posedge clk_in) disable iff (reset_in)
    (pending_q[IDX_DMA] && !(ack_in && ack_line_in == 5'h13))
      |=> pending_q[IDX_DMA];
  endproperty
  a_hold: assert property (p_hold)
    else $error("pending dropped without ack");

  property p_nmi;
    @(posedge clk_in) disable iff (reset_in)
    watchdog_irq_in |=> nmi_out;
  endproperty
  a_nmi: assert property (p_nmi)
    else $error("watchdog not on nmi");

  property p_valid;
    @(posedge clk_in) disable iff (reset_in)
    (|cand_w) |=> req_out.valid;
  endproperty
  a_valid: assert property (p_valid)
    else $error("no request while enabled pending");

  property p_range;
    @(posedge clk_in) disable iff (reset_in)
    req_out.valid |-> req_out.line >= 5'h0c && req_out.line <= 5'h14;
  endproperty
  a_range: assert property (p_range)
    else $error("line out of range");

  property p_tie;
    @(posedge clk_in) disable iff (reset_in)
    (cand_w[0] && cand_w[1] && prio_q[0] == prio_q[1]
      && prio_q[0] == 8'h00) |=> req_out.line == 5'h0c;
  endproperty
  a_tie: assert property (p_tie)
    else $error("tie not lowest line");

  property p_prio;
    @(posedge clk_in) disable iff (reset_in)
    (cand_w[0] && cand_w[8] && prio_q[8] < prio_q[0])
      |=> req_out.line != 5'h0c;
  endproperty
  a_prio: assert property (p_prio)
    else $error("less urgent line chosen");

  property p_rst;
    @(posedge clk_in) reset_in |=> prio_q[3] == 8'h00;
  endproperty
  a_rst: assert property (p_rst)
    else $error("priority not cleared");

  // Line that the request currently names, for the check below
  wire logic [NUM_LINES-1:0] shown_w;
  assign shown_w = req_q.valid ? (NUM_LINES'(1) << line_to_idx(req_q.line))
                               : '0;

  property p_mask;
    @(posedge clk_in) disable iff (reset_in)
    req_out.valid |-> (shown_w & $past(enable_in) & $past(pending_q)) != '0;
  endproperty
  a_mask: assert property (p_mask)
    else $error("presented line not enabled and pending");

  sequence s_stray_ack;
    ack_in && (ack_line_in < 5'h0c || ack_line_in > 5'h14);
  endsequence

  property p_refuse;
    @(posedge clk_in) disable iff (reset_in)
    s_stray_ack |=> (pending_q & $past(pending_q)) == $past(pending_q);
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("ignored acknowledge cleared a line");

  sequence s_ack_xtal;
    ack_in && ack_line_in == 5'h14 && !raw_w[IDX_XTAL];
  endsequence

  property p_clear;
    @(posedge clk_in) disable iff (reset_in)
    s_ack_xtal |=> !pending_q[IDX_XTAL]
                   ##1 !(req_out.valid && req_out.line == 5'h14);
  endproperty
  a_clear: assert property (p_clear)
    else $error("acknowledged line still shown");

  property p_wd_apart;
    @(posedge clk_in) disable iff (reset_in)
    (watchdog_irq_in && raw_w == '0 && pending_q == '0) |=> pending_q == '0;
  endproperty
  a_wd_apart: assert property (p_wd_apart)
    else $error("watchdog set a numbered line");

endmodule // ilmp_irq_arbiter

// ==== verification/ilmp_cpu_model.sv ====
`timescale 1ns/100ps
module ilmp_cpu_model
  import ilmp_pkg::*;
(
  // Control
  input  wire logic              clk_in,
  input  wire logic              en_in,
  input  wire logic              stray_in,
  input  wire logic [LINE_W-1:0] stray_line_in,
  // Arbiter side
  input  wire ilmp_req_t         req_in,
  output logic                   ack_out,
  output logic [LINE_W-1:0]      ack_line_out
);
  logic [1:0] hold_q = 2'h0;
  wire        take = en_in && req_in.valid && hold_q == 2'h0;
  initial ack_out = 1'b0;
  initial ack_line_out = 5'h1f;
  // Skip two edges: req lags an ack by that much
  always @(posedge clk_in)
  begin
    ack_out <= #1 take | stray_in;
    ack_line_out <= #1 take ? req_in.line
                    : (stray_in ? stray_line_in : ~ack_line_out);
    hold_q <= take ? 2'h2 : (hold_q == 2'h0 ? 2'h0 : hold_q - 2'h1);
  end
endmodule // ilmp_cpu_model

// ==== verification/tb_irq_line_map_and_priority.sv ====
`timescale 1ns/100ps
module tb_irq_line_map_and_priority;
  import ilmp_pkg::*;
  logic clk_in = 0, reset_in = 1, watchdog_irq_in = 0, cpu_en = 0, stray = 0;
  logic ack_in, nmi_out;
  ilmp_src_t            src_in = '0;
  ilmp_prio_wr_t        prio_wr_in = '0;
  ilmp_req_t            req_out;
  logic [NUM_LINES-1:0] enable_in = '1, pending_out, left;
  logic [LINE_W-1:0]    ack_line_in, stray_line = 5'h1f;
  logic [7:0]           pr [9];
  logic [4:0]           q [$];
  int n_fail = 0, compares = 0, seed = 32, k, i, b;

  ilmp_irq_arbiter dut (.clk_in, .reset_in, .src_in, .watchdog_irq_in,
    .prio_wr_in, .enable_in, .ack_in, .ack_line_in, .nmi_out, .req_out,
    .pending_out);
  ilmp_cpu_model cpu (.clk_in, .en_in(cpu_en), .req_in(req_out),
    .stray_in(stray), .stray_line_in(stray_line),
    .ack_out(ack_in), .ack_line_out(ack_line_in));

  initial forever #20 clk_in = ~clk_in;

  task chk(input logic [8:0] seen, input logic [8:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task drain;
    cpu_en = 1;
    repeat (80) if (q.size() != 0) step(1);
    step(4);
    cpu_en = 0;
    chk(9'(q.size()), 9'h0);
  endtask

  task print_verdict;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // Served line is the oldest note
  // ----------------------------------------
  always @(posedge clk_in)
    if (ack_in === 1'b1 && ack_line_in !== stray_line)
      chk(9'(ack_line_in), 9'(q.pop_front()));

  initial
  begin
    #100000;
    n_fail++;
    print_verdict;
  end

  initial
  begin
    for (i = 0; i < 9; i++) pr[i] = 8'h00;
    step(10);
    reset_in = 0;
    chk(9'(req_out), 9'h0);
    chk(pending_out, 9'h0);
    // ----------------------------------------
    // Each source onto its line
    // ----------------------------------------
    for (k = 0; k < 11; k++)
    begin
      b = k < 4 ? k : (k < 7 ? 4 : k - 2);
      src_in = 11'h400 >> k;
      step(1);
      chk(pending_out, 9'h1 << b);
      src_in = '0;
      q.push_back(5'(FIRST_LINE + b));
      drain();
    end
    // ----------------------------------------
    // Arbitration; round 0 keeps reset priorities
    // ----------------------------------------
    for (k = 0; k < 5; k++)
    begin
      for (i = 0; i < 9 && k > 0; i++)
      begin
        pr[i] = k == 1 ? 8'h05 : 8'($random(seed) & 3);
        prio_wr_in = {1'b1, i[3:0], pr[i]};
        step(1);
      end
      prio_wr_in.we = 1'b0;
      b = {$random(seed)} % 9;
      enable_in = ~(9'h1 << b);
      src_in = '1;
      step(1);
      src_in = '0;
      // Refused acknowledges on every line outside 12..20 clear nothing
      for (i = 21; i < 44 && k == 0; i++)
      begin
        stray_line = 5'(i);
        stray = 1;
        step(1);
        stray = 0;
        step(2);
      end
      chk(pending_out, 9'h1ff);
      left = enable_in;
      repeat (8)
      begin
        i = -1;
        for (int j = 0; j < 9; j++)
          if (left[j] && (i < 0 || pr[j] < pr[i])) i = j;
        q.push_back(5'(FIRST_LINE + i));
        left[i] = 1'b0;
      end
      drain();
      chk(pending_out, 9'h1 << b);
      enable_in = '1;
      q.push_back(5'(FIRST_LINE + b));
      drain();
    end
    // ----------------------------------------
    // Watchdog onto the non-maskable input
    // ----------------------------------------
    watchdog_irq_in = 1;
    step(1);
    chk(9'(nmi_out), 9'h1);
    chk(9'(req_out.valid), 9'h0);
    watchdog_irq_in = 0;
    step(1);
    chk(9'(nmi_out), 9'h0);
    print_verdict;
  end
endmodule // tb_irq_line_map_and_priority
